// ### verilog/mmd_decoder.sv
/*
 Address map decoder: steers each access to SDRAM, an async bank, a register block, internal memory (no select, no error) or error.
 Assumes requests arrive on ref_clk from core or peripheral DMA; one result per request.
*/
`timescale 1ns/1ps
// Contract
// - All addresses 32-bit, one flat space
// - External bus is 16 bits wide
// - SDRAM region programmable up to 128M bytes
// - Track one open row per SDRAM bank
// - Each async bank is fixed 1M segment
// - No separate I/O space; registers memory-mapped
// - Two register blocks near top of space
// - Registers only for supervisor core accesses
// - Boot uses first async bank select
module mmd_decoder #(
    parameter int SDRAM_BANK_COUNT = mmd_pkg::SDRAM_BANKS,
    parameter int SDRAM_ROW_BITS = mmd_pkg::ROW_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [mmd_pkg::ADDR_W-1:0] req_addr,
    input wire logic req_write,
    input wire logic req_from_dma,
    input wire logic req_supervisor,
    input wire logic [mmd_pkg::SDRAM_SIZE_W-1:0] sdram_size_sel,
    input wire logic boot_from_flash,
    output logic resp_valid,
    output logic resp_error,
    output logic resp_write,
    output logic [mmd_pkg::ADDR_W-1:0] resp_offset,
    output logic [mmd_pkg::EXT_DATA_W/8-1:0] ext_lane_en,
    output logic external_bus_unit_sel,
    output logic sdram_sel,
    output logic sdram_row_hit,
    output logic [1:0] sdram_bank,
    output logic async_bank0_select_n,
    output logic [2:0] async_upper_bank_selects_n,
    output logic core_reg_sel,
    output logic mapped_control_register_sel,
    output logic boot_fetch
);
    import mmd_pkg::*;

    // Byte address inside [base, base + size)
    function automatic logic in_region(input logic [31:0] a, input logic [31:0] base,
                                       input logic [31:0] size);
        in_region = (a >= base) && ((a - base) < size);
    endfunction

    function automatic logic [1:0] lane_of(input logic a0);
        // Even byte rides the low lane of the 16-bit bus
        lane_of = a0 ? 2'b10 : 2'b01;
    endfunction

    function automatic logic [1:0] bank_of(input logic [31:0] off);
        bank_of = off[BANK_LSB+1:BANK_LSB];
    endfunction

    logic [31:0] sdram_limit;
    logic [31:0] a_off;
    logic [1:0] async_idx;
    logic reg_ok;
    logic row_hit;
    mmd_target_e tgt;

    // Next values of the registered outputs
    logic next_resp_valid;
    logic next_resp_write;
    logic next_resp_error;
    logic [31:0] next_resp_offset;
    logic [1:0] next_lane_en;
    logic next_ebu_sel;
    logic next_sdram_sel;
    logic next_row_hit;
    logic [1:0] next_sdram_bank;
    logic next_bank0_n;
    logic [2:0] next_upper_n;
    logic next_core_sel;
    logic next_sys_sel;
    logic next_boot_fetch;

    // SDRAM size: 16M << sel, clamped at 128M
    always_comb begin
        case (sdram_size_sel)
            3'h0: sdram_limit = 32'h0100_0000;
            3'h1: sdram_limit = 32'h0200_0000;
            3'h2: sdram_limit = 32'h0400_0000;
            default: sdram_limit = SDRAM_MAX_SIZE;
        endcase
    end

    // Supervisor core accesses only; DMA sees reserved space
    assign reg_ok = req_supervisor && !req_from_dma;

    always_comb begin
        // One flat 32-bit decode for memory and registers alike
        tgt = MMD_TGT_NONE;
        a_off = 32'h0000_0000;
        if (in_region(req_addr, SDRAM_BASE, sdram_limit)) begin
            tgt = MMD_TGT_SDRAM;
            a_off = req_addr - SDRAM_BASE;
        end else if (in_region(req_addr, ASYNC_BASE, ASYNC_SEG_SIZE * ASYNC_BANKS)) begin
            tgt = MMD_TGT_ASYNC;
            a_off = req_addr - ASYNC_BASE;
        end else if (in_region(req_addr, INT_MEM_BASE, INT_MEM_SIZE)) begin
            tgt = MMD_TGT_INT_MEM;
            a_off = req_addr - INT_MEM_BASE;
        end else if (in_region(req_addr, SYS_REG_BASE, REG_BLOCK_SIZE) && reg_ok) begin
            tgt = MMD_TGT_SYS_REG;
            a_off = req_addr - SYS_REG_BASE;
        end else if (in_region(req_addr, CORE_REG_BASE, REG_BLOCK_SIZE) && reg_ok) begin
            tgt = MMD_TGT_CORE_REG;
            a_off = req_addr - CORE_REG_BASE;
        end
    end

    // Segment index from the 1M granule, device size ignored
    assign async_idx = a_off[21:20];

    // Open-row state per SDRAM bank
    mmd_row_tracker #(
        .BANKS(SDRAM_BANK_COUNT),
        .ROW_BITS(SDRAM_ROW_BITS)
    ) u_rows (
        .ref_clk(ref_clk),
        .rst(rst),
        .lookup(req_valid && (tgt == MMD_TGT_SDRAM)),
        .bank(bank_of(a_off)),
        .row(a_off[ROW_LSB+SDRAM_ROW_BITS-1:ROW_LSB]),
        .close_all(1'b0),
        .hit(row_hit)
    );

    // Response and selects, one cycle after the request
    always_comb begin
        next_resp_valid = req_valid;
        next_resp_write = 1'b0;
        next_resp_error = 1'b0;
        next_resp_offset = 32'h0000_0000;
        next_lane_en = 2'b00;
        next_ebu_sel = 1'b0;
        next_sdram_sel = 1'b0;
        next_row_hit = 1'b0;
        next_sdram_bank = 2'b00;
        next_bank0_n = 1'b1;
        next_upper_n = 3'b111;
        next_core_sel = 1'b0;
        next_sys_sel = 1'b0;
        next_boot_fetch = 1'b0;
        if (req_valid) begin
            next_resp_offset = a_off;
            next_resp_write = req_write;
            case (tgt)
                MMD_TGT_SDRAM: begin
                    next_ebu_sel = 1'b1;
                    next_sdram_sel = 1'b1;
                    // Hit reflects the row state before this access
                    next_row_hit = row_hit;
                    next_sdram_bank = bank_of(a_off);
                    next_lane_en = lane_of(a_off[0]);
                end
                MMD_TGT_ASYNC: begin
                    next_ebu_sel = 1'b1;
                    next_lane_en = lane_of(a_off[0]);
                    next_resp_offset = {12'h000, a_off[19:0]};
                    if (async_idx == 2'd0) begin
                        next_bank0_n = 1'b0;
                        next_boot_fetch = boot_from_flash && !req_write;
                    end else begin
                        next_upper_n[async_idx - 2'd1] = 1'b0;
                    end
                end
                MMD_TGT_CORE_REG: next_core_sel = 1'b1;
                MMD_TGT_SYS_REG: next_sys_sel = 1'b1;
                MMD_TGT_INT_MEM: next_resp_error = 1'b0;
                default: begin
                    // Reserved, denied or unmapped: no select at all
                    next_resp_error = 1'b1;
                    next_resp_offset = 32'h0000_0000;
                end
            endcase
        end
    end

    // Every output leaves from a flip-flop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_error <= 1'b0;
            resp_write <= 1'b0;
            resp_offset <= '0;
            ext_lane_en <= '0;
            external_bus_unit_sel <= 1'b0;
            sdram_sel <= 1'b0;
            sdram_row_hit <= 1'b0;
            sdram_bank <= 2'b00;
            async_bank0_select_n <= 1'b1;
            async_upper_bank_selects_n <= 3'b111;
            core_reg_sel <= 1'b0;
            mapped_control_register_sel <= 1'b0;
            boot_fetch <= 1'b0;
        end else begin
            resp_valid <= next_resp_valid;
            resp_error <= next_resp_error;
            resp_write <= next_resp_write;
            resp_offset <= next_resp_offset;
            ext_lane_en <= next_lane_en;
            external_bus_unit_sel <= next_ebu_sel;
            sdram_sel <= next_sdram_sel;
            sdram_row_hit <= next_row_hit;
            sdram_bank <= next_sdram_bank;
            async_bank0_select_n <= next_bank0_n;
            async_upper_bank_selects_n <= next_upper_n;
            core_reg_sel <= next_core_sel;
            mapped_control_register_sel <= next_sys_sel;
            boot_fetch <= next_boot_fetch;
        end
    end
endmodule

// ### verilog/mmd_pkg.sv
/*
 Constants for the memory map bank decoder: region bases, sizes, bit positions, target codes.
 Assumes a flat 32-bit byte address space shared by all requesters.
*/
package mmd_pkg;
    localparam int ADDR_W = 32;
    localparam int EXT_DATA_W = 16;
    localparam int SDRAM_BANKS = 4;
    localparam int ROW_W = 13;
    localparam int ASYNC_BANKS = 4;
    // Fixed segment per async bank, 1M byte
    localparam logic [31:0] ASYNC_SEG_SIZE = 32'h0010_0000;
    localparam logic [31:0] ASYNC_BASE = 32'h2000_0000;
    // SDRAM window ceiling, 128M bytes
    localparam logic [31:0] SDRAM_BASE = 32'h0000_0000;
    localparam logic [31:0] SDRAM_MAX_SIZE = 32'h0800_0000;
    localparam logic [31:0] SYS_REG_BASE = 32'hFFC0_0000;
    localparam logic [31:0] CORE_REG_BASE = 32'hFFE0_0000;
    localparam logic [31:0] REG_BLOCK_SIZE = 32'h0020_0000;
    // Internal memory region, decoded elsewhere
    localparam logic [31:0] INT_MEM_BASE = 32'hFF80_0000;
    localparam logic [31:0] INT_MEM_SIZE = 32'h0040_0000;
    localparam int SDRAM_SIZE_W = 3;
    // Row bit position and bank bit position within an SDRAM address
    localparam int ROW_LSB = 12;
    localparam int BANK_LSB = 25;
    typedef enum logic [5:0] {
        MMD_TGT_NONE = 6'b00_0001,
        MMD_TGT_SDRAM = 6'b00_0010,
        MMD_TGT_ASYNC = 6'b00_0100,
        MMD_TGT_CORE_REG = 6'b00_1000,
        MMD_TGT_SYS_REG = 6'b01_0000,
        MMD_TGT_INT_MEM = 6'b10_0000
    } mmd_target_e;
endpackage

// ### verilog/mmd_row_tracker.sv
/*
 Per-bank open-row tracker for the SDRAM path.
 Assumes one lookup per cycle; close_all clears every open row.
*/
`timescale 1ns/1ps
module mmd_row_tracker #(
    parameter int BANKS = 4,
    parameter int ROW_BITS = 13
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic lookup,
    input wire logic [$clog2(BANKS)-1:0] bank,
    input wire logic [ROW_BITS-1:0] row,
    input wire logic close_all,
    output logic hit
);
    logic [ROW_BITS-1:0] open_row [BANKS];
    logic [BANKS-1:0] open_valid;
    logic [ROW_BITS-1:0] next_open_row [BANKS];
    logic [BANKS-1:0] next_open_valid;

    assign hit = open_valid[bank] && (open_row[bank] == row);

    always_comb begin
        next_open_row = open_row;
        next_open_valid = open_valid;
        if (close_all) begin
            next_open_valid = '0;
        end else if (lookup && !hit) begin
            // Miss opens the new row in this bank only
            next_open_row[bank] = row;
            next_open_valid[bank] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            open_valid <= '0;
            for (int i = 0; i < BANKS; i++) begin
                open_row[i] <= '0;
            end
        end else begin
            open_valid <= next_open_valid;
            open_row <= next_open_row;
        end
    end
endmodule

// ### tb/mmd_chk.sv
/*
 Port checker for mmd_decoder.
 Assumes bind from tb; single clock, sync reset.
*/
`timescale 1ns/1ps
module mmd_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic req_from_dma,
    input wire logic req_supervisor,
    input wire logic [2:0] sdram_size_sel,
    input wire logic boot_from_flash,
    input wire logic resp_valid,
    input wire logic resp_error,
    input wire logic [1:0] ext_lane_en,
    input wire logic external_bus_unit_sel,
    input wire logic sdram_sel,
    input wire logic sdram_row_hit,
    input wire logic async_bank0_select_n,
    input wire logic [2:0] async_upper_bank_selects_n,
    input wire logic core_reg_sel,
    input wire logic mapped_control_register_sel,
    input wire logic boot_fetch
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_ext;
        req_valid ##1 external_bus_unit_sel;
    endsequence
    sequence s_sd;
        req_valid && req_addr[31:27] == 5'h00 && sdram_size_sel >= 3'h3;
    endsequence
    property p_resp;
        req_valid |=> resp_valid;
    endproperty
    a_resp: assert property (p_resp) else $error("no answer");
    property p_async;
        req_valid && req_addr[31:22] == 10'h080 |=> !resp_error && external_bus_unit_sel
            && {async_upper_bank_selects_n, async_bank0_select_n}
            == ~(4'h1 << $past(req_addr[21:20]));
    endproperty
    a_async: assert property (p_async) else $error("async bank select");
    property p_dma_reg;
        req_valid && req_from_dma && req_addr[31:22] == 10'h3FF
            |=> resp_error && !core_reg_sel && !mapped_control_register_sel;
    endproperty
    a_dma_reg: assert property (p_dma_reg) else $error("dma reached regs");
    property p_core;
        req_valid && !req_from_dma && req_supervisor && req_addr[31:21] == 11'h7FF
            |=> core_reg_sel && !resp_error;
    endproperty
    a_core: assert property (p_core) else $error("core regs");
    property p_err;
        resp_error |-> async_bank0_select_n && async_upper_bank_selects_n == 3'h7
            && !sdram_sel && !core_reg_sel && !mapped_control_register_sel;
    endproperty
    a_err: assert property (p_err) else $error("select on error");
    property p_lane;
        s_ext |-> ext_lane_en == {$past(req_addr[0]), !$past(req_addr[0])};
    endproperty
    a_lane: assert property (p_lane) else $error("lane enables");
    property p_hit;
        s_sd ##1 (s_sd and (req_addr == $past(req_addr))) |=> sdram_sel && sdram_row_hit;
    endproperty
    a_hit: assert property (p_hit) else $error("row hit");
    property p_boot;
        req_valid && boot_from_flash && !req_write && req_addr[31:20] == 12'h200
            |=> boot_fetch && !async_bank0_select_n;
    endproperty
    a_boot: assert property (p_boot) else $error("boot fetch");
endmodule

// ### tb/mmd_mem_model.sv
/*
 External memory side: records the last bank selection seen.
 Assumes registered active-low async selects.
*/
`timescale 1ns/1ps
module mmd_mem_model (
    input wire logic ref_clk,
    input wire logic bank0_n,
    input wire logic [2:0] upper_n,
    input wire logic sdram_sel,
    output logic [4:0] last_sel
);
    always_ff @(posedge ref_clk) begin
        if (!bank0_n || upper_n != 3'h7 || sdram_sel) begin
            last_sel <= {sdram_sel, ~upper_n, ~bank0_n};
        end
    end
endmodule

// ### tb/tb.sv
/*
 Testbench for mmd_decoder.
 Assumes inputs driven on falling edge, one-cycle answer.
*/
`timescale 1ns/1ps
module tb;
    import mmd_pkg::*;
    logic ref_clk = 0, rst = 1, rv = 0, wr = 0, dma = 0, sup = 0, boot = 0;
    logic [31:0] addr = 0;
    logic [2:0] ssel = 3'h3;
    logic rvl, rerr, rwr, ebu, sds, hit, b0n, core, sys, bf;
    logic [31:0] off;
    logic [1:0] lane, bank;
    logic [2:0] upn;
    logic [4:0] last;
    int checks = 0, n_fail = 0;
    mmd_decoder u_dut (.ref_clk(ref_clk), .rst(rst), .req_valid(rv), .req_addr(addr),
        .req_write(wr), .req_from_dma(dma), .req_supervisor(sup), .sdram_size_sel(ssel),
        .boot_from_flash(boot), .resp_valid(rvl), .resp_error(rerr), .resp_write(rwr),
        .resp_offset(off), .ext_lane_en(lane), .external_bus_unit_sel(ebu),
        .sdram_sel(sds), .sdram_row_hit(hit), .sdram_bank(bank),
        .async_bank0_select_n(b0n), .async_upper_bank_selects_n(upn),
        .core_reg_sel(core), .mapped_control_register_sel(sys), .boot_fetch(bf));
    mmd_mem_model u_mem (.ref_clk(ref_clk), .bank0_n(b0n), .upper_n(upn),
        .sdram_sel(sds), .last_sel(last));
    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task acc(input logic [31:0] a, input logic d, input logic s, input logic w);
        @(negedge ref_clk);
        rv = 1;
        addr = a;
        dma = d;
        sup = s;
        wr = w;
        @(negedge ref_clk);
        rv = 0;
    endtask
    task t_async;
        for (int b = 0; b < 5; b++) begin
            acc(ASYNC_BASE + b * ASYNC_SEG_SIZE + 32'h0000_0005, 1, 0, 0);
            chk("err", rerr, b == 4);
            chk("ebu", ebu, b < 4);
            chk("sel", {upn, b0n}, 4'(~(5'h01 << b)));
            if (b < 4) begin
                chk("off", off, 32'h0000_0005);
                chk("lane", lane, 2'b10);
                @(negedge ref_clk);
                chk("mem", last, 5'h01 << b);
            end
        end
        $display("done async");
    endtask
    task t_sdram;
        acc(32'h0100_0000, 0, 1, 0);
        chk("size", rerr, 0);
        ssel = 3'h0;
        acc(32'h0100_0000, 0, 1, 0);
        chk("size", rerr, 1);
        ssel = 3'h3;
        @(negedge ref_clk);
        rv = 1;
        wr = 1;
        addr = 32'h0000_1000;
        @(negedge ref_clk);
        chk("hit0", {sds, hit, rwr}, 3'b101);
        @(negedge ref_clk);
        rv = 0;
        chk("hit1", {sds, hit, bank}, 4'b1100);
        acc(32'h0200_1000, 0, 1, 0);
        chk("bank1", {hit, bank, rwr}, 4'b0010);
        $display("done sdram");
    endtask
    task t_regs;
        static logic [31:0] ad[6] = '{32'hFFE0_0010, 32'hFFC0_0010, 32'hFFE0_0010,
            32'hFFC0_0010, 32'h4000_0000, 32'hFF80_0000};
        static logic [4:0] fl[6] = '{5'h0A, 5'h09, 5'h04, 5'h1C, 5'h0C, 5'h08};
        for (int i = 0; i < 6; i++) begin
            acc(ad[i], fl[i][4], fl[i][3], 0);
            chk("reg", {rvl, rerr, core, sys}, {1'b1, fl[i][2:0]});
        end
        $display("done regs");
    endtask
    task t_boot;
        boot = 1;
        acc(ASYNC_BASE, 0, 1, 0);
        chk("boot0", {bf, b0n}, 2'b10);
        acc(ASYNC_BASE + ASYNC_SEG_SIZE, 0, 1, 0);
        chk("boot1", {bf, upn}, 4'h6);
        boot = 0;
        $display("done boot");
    endtask
    task give_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        rst = 0;
        t_async();
        t_sdram();
        t_regs();
        t_boot();
        give_verdict();
    end
endmodule
bind mmd_decoder mmd_chk u_chk (.*);
